// [mpu_core_sfr.sv]
// Behaviour
// (R1) bank bits 4:3 pick register bank base
// (R2) status bit 0 gives accumulator even parity
// (R3) status bits 5 and 1 plain user flags
// (R4) bits 7,6,2 hold carry, aux carry, overflow
// (R5) stack pointer is 8 bits, resets 0x07
// (R6) stack pointer pre-incremented before each push
// (R7) two 16-bit data pointers at 0x82-0x85
// (R8) pointer bytes writable; selected pointer addresses memory
// (R9) program counter 16 bits, reset 0, increments
// (R10) four port registers cover pins 0-15
// (R11) upper nibble direction, lower nibble output level
// (R12) direction one is output, zero is input
// (R13) output bit drives pin high or low
// (R14) port read returns actual pin state
// (R15) pins reset outputs but float until enabled
// (R16) 3-bit stretch field, resets to one
// (R17) stretch applies to every external data move
// (R18) read address and strobe last stretch+1
// (R19) write address stretch+2, strobe max(stretch,1)
// (R20) core executes the standard instruction set
`timescale 1ns/1ps
`default_nettype none
`include "mpu_sfr_regs.svh"
module mpu_core_sfr
   import mpu_sfr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   output var  logic [7:0]  sfr_rdata,
   input  wire logic [7:0]  acc_in,
   input  wire logic        flags_we,
   input  wire logic        carry_in,
   input  wire logic        aux_carry_in,
   input  wire logic        overflow_in,
   input  wire logic        stack_push,
   input  wire logic        stack_pop,
   output var  logic [7:0]  stack_pointer,
   output var  logic [7:0]  stack_addr,
   output var  logic [7:0]  bank_base,
   input  wire logic        pc_inc,
   input  wire logic        pc_load,
   input  wire logic [15:0] pc_load_val,
   output var  logic [15:0] program_counter,
   input  wire logic        port_enable,
   input  wire logic [15:0] pins_in,
   output var  logic [15:0] pin_out,
   output var  logic [15:0] pin_oe,
   input  wire logic        movx_start,
   input  wire logic        movx_write,
   input  wire logic [7:0]  movx_wdata,
   output var  logic        movx_busy,
   output var  logic        movx_done,
   output var  logic [7:0]  movx_rdata,
   output var  logic [15:0] mem_addr,
   output var  logic        mem_addr_valid,
   output var  logic [7:0]  mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   output var  logic        mem_rd,
   output var  logic        mem_wr
);
   // ==================================================
   // helpers
   // port register index for an address, bit 2 flags a hit
   function automatic logic [2:0] port_decode(input logic [7:0] a);
      logic [2:0] r;
      r = 3'h0;
      case (a)
         `ADDR_PORT0: r = 3'h4;
         `ADDR_PORT1: r = 3'h5;
         `ADDR_PORT2: r = 3'h6;
         `ADDR_PORT3: r = 3'h7;
         default:     r = 3'h0;
      endcase
      return r;
   endfunction

   // cycles that the address phase lasts
   function automatic logic [3:0] addr_len(input logic wr, input logic [2:0] s);
      return wr ? ({1'b0, s} + 4'h2) : ({1'b0, s} + 4'h1);
   endfunction

   // cycles that the strobe lasts; a write strobe never drops to zero
   function automatic logic [3:0] strobe_len(input logic wr, input logic [2:0] s);
      logic [3:0] r;
      r = {1'b0, s};
      if (!wr) begin
         r = {1'b0, s} + 4'h1;
      end else if (s == 3'h0) begin
         r = 4'h1;
      end
      return r;
   endfunction

   logic [7:0]  sp_q;
   logic [7:0]  stack_addr_q;
   logic [7:0]  psw_q;
   logic [15:0] dp0_q;
   logic [15:0] dp1_q;
   logic        dp_sel_q;
   logic [2:0]  stretch_q;
   logic [15:0] pc_q;
   sfr_byte_t   port_q [4];
   logic [15:0] dir_w;
   logic [15:0] lvl_w;
   logic [2:0]  wr_port;
   logic [7:0]  rdata_d;
   movx_state_t mx_q;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_n;
   logic [2:0]  cyc_stretch_q;

   // ==================================================
   // register writes
   assign wr_port = port_decode(sfr_addr);

   // status word: alu flag updates win over a software write in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         psw_q <= `RST_PSW;
      end else begin
         if (sfr_wr && sfr_addr == `ADDR_PSW) begin
            psw_q[7:1] <= sfr_wdata[7:1]; // bits 5,1 plain storage, see R3
         end
         if (flags_we) begin
            psw_q[`PSW_CARRY]     <= carry_in;     // see R4
            psw_q[`PSW_AUX_CARRY] <= aux_carry_in; // see R4
            psw_q[`PSW_OVERFLOW]  <= overflow_in;  // see R4
         end
         psw_q[`PSW_PARITY] <= ^acc_in; // tracks the accumulator every cycle, see R2
      end
   end

   // register bank base: bank number times eight
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_base <= 8'h00;
      end else if (sfr_wr && sfr_addr == `ADDR_PSW) begin
         bank_base <= {3'h0, sfr_wdata[`PSW_BANK_HI:`PSW_BANK_LO], 3'h0}; // see R1
      end
   end

   // stack pointer; core strobes win over a software write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_q         <= `RST_SP; // see R5
         stack_addr_q <= 8'h00;
      end else if (stack_push) begin
         sp_q         <= sp_q + 8'h01; // pre-increment, see R6
         stack_addr_q <= sp_q + 8'h01; // see R6
      end else if (stack_pop) begin
         sp_q         <= sp_q - 8'h01;
         stack_addr_q <= sp_q;
      end else if (sfr_wr && sfr_addr == `ADDR_SP) begin
         sp_q <= sfr_wdata;
      end
   end

   // data pointers, each byte its own register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dp0_q    <= `RST_DP;
         dp1_q    <= `RST_DP;
         dp_sel_q <= 1'b0;
      end else if (sfr_wr) begin
         case (sfr_addr)
            `ADDR_DP0_LO:    dp0_q[7:0]  <= sfr_wdata; // see R7
            `ADDR_DP0_HI:    dp0_q[15:8] <= sfr_wdata; // see R8
            `ADDR_DP1_LO:    dp1_q[7:0]  <= sfr_wdata; // see R7
            `ADDR_DP1_HI:    dp1_q[15:8] <= sfr_wdata; // see R8
            `ADDR_DP_SELECT: dp_sel_q    <= sfr_wdata[0];
            default:         dp_sel_q    <= dp_sel_q;
         endcase
      end
   end

   // stretch field, upper bits not stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stretch_q <= `RST_STRETCH; // see R16
      end else if (sfr_wr && sfr_addr == `ADDR_STRETCH) begin
         stretch_q <= sfr_wdata[`STRETCH_MSB:0]; // see R16
      end
   end

   // program counter; the core decides when fetches happen, see R20
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= `RST_PC; // see R9
      end else if (pc_load) begin
         pc_q <= pc_load_val;
      end else if (pc_inc) begin
         pc_q <= pc_q + 16'h0001; // see R9
      end
   end

   // port latches, reset to all outputs driving high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            port_q[i] <= `RST_PORT; // see R15
         end
      end else if (sfr_wr && wr_port[2]) begin
         port_q[wr_port[1:0]] <= sfr_wdata; // one write sets dir and level, see R11
      end
   end

   // ==================================================
   // pins
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         dir_w[4*i +: 4] = port_q[i][7:`PORT_DIR_LSB]; // see R10
         lvl_w[4*i +: 4] = port_q[i][3:0];             // see R10
      end
   end

   // drivers stay off until the global enable, so a half-configured port never glitches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 16'hffff;
         pin_oe  <= 16'h0000;
      end else begin
         pin_out <= lvl_w;                        // see R13
         pin_oe  <= dir_w & {16{port_enable}};    // see R12 and R15
      end
   end

   // ==================================================
   // register reads, one cycle after the strobe
   always_comb begin
      rdata_d = 8'h00;
      case (sfr_addr)
         `ADDR_SP:        rdata_d = sp_q;
         `ADDR_DP0_LO:    rdata_d = dp0_q[7:0];
         `ADDR_DP0_HI:    rdata_d = dp0_q[15:8];
         `ADDR_DP1_LO:    rdata_d = dp1_q[7:0];
         `ADDR_DP1_HI:    rdata_d = dp1_q[15:8];
         `ADDR_DP_SELECT: rdata_d = {7'h00, dp_sel_q};
         `ADDR_STRETCH:   rdata_d = {5'h00, stretch_q};
         `ADDR_PSW:       rdata_d = psw_q;
         default:         rdata_d = 8'h00;
      endcase
      if (wr_port[2]) begin
         // live pin level, not the latch, see R14
         rdata_d = {port_q[wr_port[1:0]][7:4], pins_in[4*wr_port[1:0] +: 4]};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= rdata_d;
      end
   end

   // ==================================================
   // external data move sequencer
   assign cnt_n = cnt_q + 4'h1;

   // stretch is latched at start, so a rewrite mid-cycle cannot bend the strobes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mx_q           <= MX_IDLE;
         cnt_q          <= 4'h0;
         cyc_stretch_q  <= `RST_STRETCH;
         mem_addr       <= 16'h0000;
         mem_addr_valid <= 1'b0;
         mem_wdata      <= 8'h00;
         mem_rd         <= 1'b0;
         mem_wr         <= 1'b0;
         movx_busy      <= 1'b0;
         movx_done      <= 1'b0;
         movx_rdata     <= 8'h00;
      end else begin
         movx_done <= 1'b0;
         case (mx_q)
            MX_IDLE: begin
               if (movx_start) begin
                  mem_addr       <= dp_sel_q ? dp1_q : dp0_q; // see R8
                  cyc_stretch_q  <= stretch_q;                // see R17
                  cnt_q          <= 4'h0;
                  mem_addr_valid <= 1'b1;
                  movx_busy      <= 1'b1;
                  mem_wdata      <= movx_wdata;
                  mem_rd         <= !movx_write;
                  mx_q           <= movx_write ? MX_WRITE : MX_READ;
               end
            end
            MX_READ: begin
               if (cnt_n == addr_len(1'b0, cyc_stretch_q)) begin
                  mem_rd         <= 1'b0; // see R18
                  mem_addr_valid <= 1'b0; // see R18
                  movx_busy      <= 1'b0;
                  movx_done      <= 1'b1;
                  movx_rdata     <= mem_rdata;
                  mx_q           <= MX_IDLE;
               end else begin
                  cnt_q <= cnt_n;
               end
            end
            MX_WRITE: begin
               // strobe sits inside the address phase, one cycle after it opens
               mem_wr <= (cnt_n != 4'h0) && (cnt_n <= strobe_len(1'b1, cyc_stretch_q)); // see R19
               if (cnt_n == addr_len(1'b1, cyc_stretch_q)) begin
                  mem_wr         <= 1'b0;
                  mem_addr_valid <= 1'b0; // see R19
                  movx_busy      <= 1'b0;
                  movx_done      <= 1'b1;
                  mx_q           <= MX_IDLE;
               end else begin
                  cnt_q <= cnt_n;
               end
            end
            default: begin
               mx_q <= MX_IDLE;
            end
         endcase
      end
   end

   assign stack_pointer   = sp_q;
   assign stack_addr      = stack_addr_q;
   assign program_counter = pc_q;

   // ==================================================
   // checks
   logic [3:0] rd_run_q;
   logic [3:0] wr_run_q;
   logic [3:0] av_run_q;
   logic       write_cyc_q;

   // run lengths of each strobe, read only by the checks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_run_q    <= 4'h0;
         wr_run_q    <= 4'h0;
         av_run_q    <= 4'h0;
         write_cyc_q <= 1'b0;
      end else begin
         rd_run_q <= mem_rd ? rd_run_q + 4'h1 : 4'h0;
         wr_run_q <= mem_wr ? wr_run_q + 4'h1 : 4'h0;
         av_run_q <= mem_addr_valid ? av_run_q + 4'h1 : 4'h0;
         if (mx_q == MX_IDLE && movx_start) begin
            write_cyc_q <= movx_write;
         end
      end
   end

   property p_bank;
      @(posedge clk) disable iff (!rst_n)
      sfr_wr && sfr_addr == `ADDR_PSW |=> bank_base == {3'h0, $past(sfr_wdata[4:3]), 3'h0};
   endproperty
   a_bank: assert property (p_bank) else $error("bank base wrong"); // see R1

   property p_parity;
      @(posedge clk) disable iff (!rst_n)
      rst_n && $past(rst_n) |-> (^{psw_q[`PSW_PARITY], $past(acc_in)}) == 1'b0;
   endproperty
   a_parity: assert property (p_parity) else $error("parity bit wrong"); // see R2

   property p_flags;
      @(posedge clk) disable iff (!rst_n)
      flags_we |=> psw_q[7] == $past(carry_in) && psw_q[6] == $past(aux_carry_in)
                   && psw_q[2] == $past(overflow_in);
   endproperty
   a_flags: assert property (p_flags) else $error("alu flags not stored"); // see R4

   property p_sp_reset;
      @(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> sp_q == 8'h07 && pc_q == 16'h0000;
   endproperty
   a_sp_reset: assert property (p_sp_reset) else $error("reset value wrong"); // see R5

   property p_push;
      @(posedge clk) disable iff (!rst_n)
      stack_push |=> sp_q == $past(sp_q) + 8'h01 && stack_addr_q == sp_q;
   endproperty
   a_push: assert property (p_push) else $error("push not pre-incremented"); // see R6

   property p_pc_inc;
      @(posedge clk) disable iff (!rst_n)
      pc_inc && !pc_load |=> pc_q == $past(pc_q) + 16'h0001;
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc did not advance"); // see R9

   property p_movx_addr;
      @(posedge clk) disable iff (!rst_n)
      mx_q == MX_IDLE && movx_start |=> mem_addr == ($past(dp_sel_q) ? $past(dp1_q) : $past(dp0_q));
   endproperty
   a_movx_addr: assert property (p_movx_addr) else $error("wrong pointer used"); // see R8

   property p_pin_drive;
      @(posedge clk) disable iff (!rst_n)
      rst_n && $past(rst_n) |-> pin_oe == ($past(dir_w) & {16{$past(port_enable)}})
                               && pin_out == $past(lvl_w);
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("pin drive wrong"); // see R12

   property p_rd_len;
      @(posedge clk) disable iff (!rst_n)
      $fell(mem_rd) |-> rd_run_q == addr_len(1'b0, cyc_stretch_q) && av_run_q == rd_run_q;
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read strobe width wrong"); // see R18

   property p_wr_len;
      @(posedge clk) disable iff (!rst_n)
      $fell(mem_wr) |-> wr_run_q == strobe_len(1'b1, cyc_stretch_q);
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write strobe width wrong"); // see R19

   property p_wr_addr;
      @(posedge clk) disable iff (!rst_n)
      $fell(mem_addr_valid) && write_cyc_q |-> av_run_q == addr_len(1'b1, cyc_stretch_q);
   endproperty
   a_wr_addr: assert property (p_wr_addr) else $error("write address width wrong"); // see R19

   c_read_fast: cover property (@(posedge clk) disable iff (!rst_n)
      mx_q == MX_READ && cyc_stretch_q == 3'h0 ##1 movx_done);
   c_write_max: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(mem_wr) && cyc_stretch_q == 3'h7);
   c_push: cover property (@(posedge clk) disable iff (!rst_n) stack_push ##1 stack_pop);
   c_enable: cover property (@(posedge clk) disable iff (!rst_n) $rose(pin_oe[0]));
endmodule
`default_nettype wire

// [mpu_sfr_regs.svh]
`ifndef MPU_SFR_REGS_SVH
`define MPU_SFR_REGS_SVH
// ==================================================
// register addresses
`define ADDR_PORT0        8'h80
`define ADDR_SP           8'h81
`define ADDR_DP0_LO       8'h82
`define ADDR_DP0_HI       8'h83
`define ADDR_DP1_LO       8'h84
`define ADDR_DP1_HI       8'h85
`define ADDR_STRETCH      8'h8e
`define ADDR_PORT1        8'h90
`define ADDR_DP_SELECT    8'h92
`define ADDR_PORT2        8'ha0
`define ADDR_PORT3        8'hb0
`define ADDR_PSW          8'hd0
// ==================================================
// reset values
`define RST_SP            8'h07
`define RST_PORT          8'hff
`define RST_DP            16'h0000
`define RST_PC            16'h0000
`define RST_PSW           8'h00
`define RST_STRETCH       3'h1
// ==================================================
// field positions
`define PSW_CARRY         7
`define PSW_AUX_CARRY     6
`define PSW_USER_FLAG0    5
`define PSW_BANK_HI       4
`define PSW_BANK_LO       3
`define PSW_OVERFLOW      2
`define PSW_USER_FLAG1    1
`define PSW_PARITY        0
`define STRETCH_MSB       2
`define PORT_DIR_LSB      4
`endif

// [mpu_sfr_pkg.sv]
package mpu_sfr_pkg;
   // external data move sequencer states
   typedef enum logic [2:0] {
      MX_IDLE  = 3'b001,
      MX_READ  = 3'b010,
      MX_WRITE = 3'b100
   } movx_state_t;
   typedef logic [7:0] sfr_byte_t;
endpackage

// [ext_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// external data memory on the movx strobes
module ext_mem_model (
   input  wire logic        clk,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   output var  logic [7:0]  mem_rdata
);
   logic [7:0] mem_q [16];
   logic [7:0] last_q = 8'h00;

   // store on every strobed cycle; a long strobe rewrites the same byte
   always @(posedge clk) begin
      if (mem_wr === 1'b1) begin
         mem_q[mem_addr[3:0]] <= mem_wdata;
      end
      if (mem_rd === 1'b1) begin
         last_q <= mem_q[mem_addr[3:0]];
      end
   end

   // released bus shows the inverse of the last byte, so stale data never passes
   always_comb begin
      mem_rdata = (mem_rd === 1'b1) ? mem_q[mem_addr[3:0]] : ~last_q;
   end
endmodule
`default_nettype wire

// [mpu_core_sfr_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mpu_sfr_regs.svh"
// ==================================================
// register, stack, counter, port and movx checks
module mpu_core_sfr_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, acc_in = 8'h00, movx_wdata = 8'h00;
   logic        sfr_wr = 1'b0, sfr_rd = 1'b0, flags_we = 1'b0, carry_in = 1'b0;
   logic        aux_carry_in = 1'b0, overflow_in = 1'b0, stack_push = 1'b0;
   logic        stack_pop = 1'b0, pc_inc = 1'b0, pc_load = 1'b0, port_enable = 1'b0;
   logic        movx_start = 1'b0, movx_write = 1'b0;
   logic [15:0] pc_load_val = 16'h0000;
   logic [15:0] ext_pins = 16'h9a53;
   logic [7:0]  sfr_rdata, stack_pointer, stack_addr, bank_base, movx_rdata;
   logic [7:0]  mem_wdata, mem_rdata;
   logic [15:0] program_counter, pin_out, pin_oe, mem_addr, exp_dir, exp_out, pv_pins;
   logic        movx_busy, movx_done, mem_addr_valid, mem_rd, mem_wr;
   wire  [15:0] pins_in;
   int          failures = 0;
   int          checks_done = 0;
   logic [7:0]  pa [4] = '{`ADDR_PORT0, `ADDR_PORT1, `ADDR_PORT2, `ADDR_PORT3};
   logic [7:0]  pv [4] = '{8'ha5, 8'h3c, 8'hf0, 8'h0f};
   logic [7:0]  accv [6] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hff, 8'h7f};

   always #5 clk = ~clk;

   // pad level: driven pins follow the block, the rest follow the outside world
   assign pins_in = (pin_oe & pin_out) | (~pin_oe & ext_pins);

   mpu_core_sfr dut (
      .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .acc_in(acc_in),
      .flags_we(flags_we), .carry_in(carry_in), .aux_carry_in(aux_carry_in),
      .overflow_in(overflow_in), .stack_push(stack_push), .stack_pop(stack_pop),
      .stack_pointer(stack_pointer), .stack_addr(stack_addr), .bank_base(bank_base),
      .pc_inc(pc_inc), .pc_load(pc_load), .pc_load_val(pc_load_val),
      .program_counter(program_counter), .port_enable(port_enable), .pins_in(pins_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .movx_start(movx_start),
      .movx_write(movx_write), .movx_wdata(movx_wdata), .movx_busy(movx_busy),
      .movx_done(movx_done), .movx_rdata(movx_rdata), .mem_addr(mem_addr),
      .mem_addr_valid(mem_addr_valid), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_rd(mem_rd), .mem_wr(mem_wr)
   );

   ext_mem_model mem (
      .clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_rdata(mem_rdata)
   );

   // ==================================================
   // bench tasks
   task automatic give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s exp %h got %h", name, exp, got);
      end
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask

   // data lands on the capture edge, so look just after it
   task automatic read_check(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 check(name, {8'h00, exp}, {8'h00, sfr_rdata});
   endtask

   // one movx transfer, counting strobe widths until done, bounded
   task automatic movx(input logic w, input logic [7:0] d, input logic [15:0] ea, input int s);
      int av, rd, wr, bs, n;
      logic done;
      av = 0;
      bs = 0;
      rd = 0;
      wr = 0;
      done = 1'b0;
      @(posedge clk);
      movx_start <= 1'b1;
      movx_write <= w;
      movx_wdata <= d;
      @(posedge clk);
      movx_start <= 1'b0;
      for (n = 0; n < 20 && !done; n++) begin
         #1;
         av += int'(mem_addr_valid === 1'b1);
         rd += int'(mem_rd === 1'b1);
         wr += int'(mem_wr === 1'b1);
         bs += int'(movx_busy === 1'b1);
         if (mem_addr_valid === 1'b1) check("mem_addr", ea, mem_addr);
         if (mem_wr === 1'b1) check("mem_wdata", {8'h00, d}, {8'h00, mem_wdata});
         if (movx_done === 1'b1) done = 1'b1;
         else @(posedge clk);
      end
      if (!done) begin
         failures++;
         give_verdict();
      end
      check("busy_width", 16'(s + 1 + int'(w)), 16'(bs));
      if (w) begin
         check("wr_addr_width", 16'(s + 2), 16'(av));
         check("wr_strobe_width", 16'((s == 0) ? 1 : s), 16'(wr));
      end else begin
         check("rd_addr_width", 16'(s + 1), 16'(av));
         check("rd_strobe_width", 16'(s + 1), 16'(rd));
         check("movx_rdata", {8'h00, d}, {8'h00, movx_rdata});
      end
   endtask

   // ==================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      read_check("sp_reset", `ADDR_SP, 8'h07);
      read_check("stretch_reset", `ADDR_STRETCH, 8'h01);
      read_check("dp0_lo_reset", `ADDR_DP0_LO, 8'h00);
      check("pc_reset", 16'h0000, program_counter);
      check("pin_oe_reset", 16'h0000, pin_oe);
      // status flags, read-only parity bit and parity tracking
      sfr_write(`ADDR_PSW, 8'h23);
      read_check("psw_user", `ADDR_PSW, 8'h22);
      foreach (accv[i]) begin
         @(posedge clk);
         acc_in <= accv[i];
         read_check("psw_parity", `ADDR_PSW, 8'h22 | {7'h00, ^accv[i]});
      end
      acc_in <= 8'h00;
      for (int b = 0; b < 4; b++) begin
         sfr_write(`ADDR_PSW, {3'b000, 2'(b), 3'b000});
         @(posedge clk);
         #1 check("bank_base", 16'(b * 8), {8'h00, bank_base});
      end
      @(posedge clk);
      {carry_in, aux_carry_in, overflow_in, flags_we} <= 4'b1011;
      @(posedge clk);
      flags_we <= 1'b0;
      read_check("psw_flags_a", `ADDR_PSW, 8'h9c);
      @(posedge clk);
      {carry_in, aux_carry_in, overflow_in, flags_we} <= 4'b0101;
      @(posedge clk);
      flags_we <= 1'b0;
      read_check("psw_flags_b", `ADDR_PSW, 8'h58);
      // stack pre-increment and pop
      @(posedge clk);
      stack_push <= 1'b1;
      @(posedge clk);
      stack_push <= 1'b0;
      #1 check("push_addr", 16'h0808, {stack_addr, stack_pointer});
      read_check("sp_after_push", `ADDR_SP, 8'h08);
      @(posedge clk);
      stack_pop <= 1'b1;
      @(posedge clk);
      stack_pop <= 1'b0;
      #1 check("pop_addr", 16'h0807, {stack_addr, stack_pointer});
      // program counter: three steps, then load near the top and wrap
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         pc_load <= (k == 3);
         pc_load_val <= 16'hffff;
         pc_inc <= (k != 3);
      end
      @(posedge clk);
      pc_inc <= 1'b0;
      #1 check("pc_wrap", 16'h0000, program_counter);
      // data pointers and an unmapped place
      sfr_write(`ADDR_DP0_LO, 8'h34);
      sfr_write(`ADDR_DP0_HI, 8'h12);
      sfr_write(`ADDR_DP1_LO, 8'hc5);
      sfr_write(`ADDR_DP1_HI, 8'hab);
      read_check("dp0_hi", `ADDR_DP0_HI, 8'h12);
      read_check("dp1_lo", `ADDR_DP1_LO, 8'hc5);
      sfr_write(8'h87, 8'hff);
      read_check("unmapped", 8'h87, 8'h00);
      // ports: configure while disabled, then enable and read live pins
      foreach (pa[i]) begin
         sfr_write(pa[i], pv[i]);
         exp_dir[i*4+:4] = pv[i][7:4];
         exp_out[i*4+:4] = pv[i][3:0];
      end
      repeat (2) @(posedge clk);
      #1 check("pin_oe_disabled", 16'h0000, pin_oe);
      @(posedge clk);
      port_enable <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check("pin_oe", exp_dir, pin_oe);
      check("pin_out", exp_out, pin_out);
      for (int k = 0; k < 2; k++) begin
         ext_pins = (k == 0) ? 16'h9a53 : 16'h65ac;
         pv_pins = (exp_dir & exp_out) | (~exp_dir & ext_pins);
         foreach (pa[i]) read_check("port_read", pa[i], {pv[i][7:4], pv_pins[i*4+:4]});
      end
      // every stretch value, alternating pointers, write then read back
      for (int s = 0; s < 8; s++) begin
         sfr_write(`ADDR_STRETCH, 8'(s));
         sfr_write(`ADDR_DP_SELECT, {7'h00, s[0]});
         read_check("stretch", `ADDR_STRETCH, 8'(s));
         movx(1'b1, 8'h30 + 8'(s), s[0] ? 16'habc5 : 16'h1234, s);
         movx(1'b0, 8'h30 + 8'(s), s[0] ? 16'habc5 : 16'h1234, s);
      end
      sfr_write(`ADDR_STRETCH, 8'hf9);
      read_check("stretch_upper", `ADDR_STRETCH, 8'h01);
      // second reset in mid-run, pins still enabled: drivers must drop at once
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      #1 check("pin_oe_rerun", 16'h0000, pin_oe);
      read_check("sp_rerun", `ADDR_SP, 8'h07);
      give_verdict();
   end
endmodule
`default_nettype wire
